// ### rtl/uscr_ctrl.sv
// What this block does
// RL1: One 8-bit control and status register.
// RL2: Bit 7 shows error flag when selector set.
// RL3: Missing stop bit sets framing error flag.
// RL4: Framing error stays set until software clears.
// RL5: Mode comes from the two mode bits.
// RL6: Decode modes shift, uart8, uart9 fixed, variable.
// RL7: Multiprocessor enable suppresses receive flag when unaddressed.
// RL8: Bit 7 writes reach only selected bit.
module uscr_ctrl (
	// Clock and reset.
	input wire logic i_mclk,
	input wire logic i_reset,
	// Special function register byte access.
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic [7:0] i_sfr_wdata,
	output logic [7:0] o_sfr_rdata,
	// Special function register bit access.
	input wire logic i_bit_wr,
	input wire logic [7:0] i_bit_addr,
	input wire logic i_bit_val,
	// Framing error selector from the power control register.
	input wire logic i_framing_error_selector,
	// Events from the serial engine.
	input wire logic i_tx_done,
	input wire logic i_rx_done,
	input wire logic i_rx_stop_bit,
	input wire logic i_rx_ninth_bit,
	// Control and status towards the serial engine.
	output logic [3:0] o_mode,
	output logic o_multiprocessor_enable,
	output logic o_receive_enable,
	output logic o_transmit_ninth_bit,
	output logic o_received_ninth_bit,
	output logic o_transmit_interrupt_flag,
	output logic o_receive_interrupt_flag,
	output logic o_framing_error_flag
);
	// Write strobes that land on this register.
	logic byte_hit;
	logic bit_base_hit;
	logic [7:0] bit_hit;
	logic sw_touch;

	// Register state: control bits, sticky error flag, read view and mode.
	logic [7:0] ctl_r, ctl_nxt;
	logic fe_r, fe_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	uscr_pkg::uscr_mode_e mode_r, mode_nxt;

	// Qualification of a finished receive frame.
	logic nine_bit_mode;
	logic eight_bit_mode;
	logic rx_accept;
	logic fe_event;

	// A byte write hits only at the register's own address.
	assign byte_hit = i_sfr_wr && (i_sfr_addr == uscr_pkg::SCS_ADDR);

	// A bit write hits when the upper address bits name this register.
	assign bit_base_hit = i_bit_wr &&
		(i_bit_addr[7:3] == uscr_pkg::SCS_BIT_BASE);

	// One strobe per bit position, picked by the low address bits.
	for (genvar k = 0; k < 8; k++) begin : g_bit_hit
		assign bit_hit[k] = bit_base_hit && (i_bit_addr[2:0] == 3'(k));
	end

	// Any software access that may change a bit of the register.
	assign sw_touch = byte_hit || bit_base_hit;

	// Frame qualification works on the stored mode bits, not the error flag.
	// The multiprocessor filter only blocks the receive flag and bit nine; the error
	// flag is still raised so that software learns of a broken frame.
	always_comb begin
		nine_bit_mode = ctl_r[uscr_pkg::BIT_SEL0_FE];
		eight_bit_mode = !ctl_r[uscr_pkg::BIT_SEL0_FE] &&
			ctl_r[uscr_pkg::BIT_SEL1];
		rx_accept = i_rx_done;
		// An unaddressed frame in a nine bit mode is dropped. [RL7]
		if (ctl_r[uscr_pkg::BIT_MP_EN] && nine_bit_mode &&
			!i_rx_ninth_bit) begin
			rx_accept = 1'b0;
		end
		// An eight bit frame without stop bit is dropped. [RL7]
		if (ctl_r[uscr_pkg::BIT_MP_EN] && eight_bit_mode &&
			!i_rx_stop_bit) begin
			rx_accept = 1'b0;
		end
		// A missing stop bit marks a framing error. [RL3]
		fe_event = i_rx_done && !i_rx_stop_bit;
	end

	// Next register contents. Software writes are applied first and the
	// hardware events afterwards, so an event in the same cycle as a
	// software clear wins and is never lost.
	always_comb begin
		ctl_nxt = ctl_r;
		fe_nxt = fe_r;
		// Byte write: bit 7 reaches only the bit that is visible. [RL8]
		if (byte_hit) begin
			ctl_nxt[6:0] = i_sfr_wdata[6:0];
			if (i_framing_error_selector) begin
				fe_nxt = i_sfr_wdata[uscr_pkg::BIT_SEL0_FE];
			end else begin
				ctl_nxt[7] = i_sfr_wdata[uscr_pkg::BIT_SEL0_FE];
			end
		end
		// Bit writes to the lower seven positions, merged in one step.
		ctl_nxt[6:0] = (ctl_nxt[6:0] & ~bit_hit[6:0]) |
			(bit_hit[6:0] & {7{i_bit_val}});
		// Bit write to position 7 follows the selector as well. [RL8]
		if (bit_hit[7]) begin
			if (i_framing_error_selector) begin
				fe_nxt = i_bit_val;
			end else begin
				ctl_nxt[7] = i_bit_val;
			end
		end
		// Transmit done raises the transmit flag. [RL1]
		if (i_tx_done) begin
			ctl_nxt[uscr_pkg::BIT_TX_FLAG] = 1'b1;
		end
		// An accepted frame raises the receive flag and stores bit nine in a nine bit mode, or the stop bit in eight bit mode.
		if (rx_accept) begin
			ctl_nxt[uscr_pkg::BIT_RX_FLAG] = 1'b1;
			if (nine_bit_mode) begin
				ctl_nxt[uscr_pkg::BIT_RX_NINTH] = i_rx_ninth_bit;
			end else if (eight_bit_mode) begin
				ctl_nxt[uscr_pkg::BIT_RX_NINTH] = i_rx_stop_bit;
			end
		end
		// The error flag is sticky: only software or reset clears it. [RL3] [RL4]
		if (fe_event) begin
			fe_nxt = 1'b1;
		end
		// Synchronous reset returns every bit to its reset value.
		if (i_reset) begin
			ctl_nxt = uscr_pkg::SCS_RESET;
			fe_nxt = 1'b0;
		end
	end

	// Read view: position 7 shows the error flag or mode bit 0. [RL1] [RL2]
	// The view is taken from the next values so that a read sees a write
	// in the same cycle as the register takes it, with no extra cycle.
	always_comb begin
		rdata_nxt = ctl_nxt;
		if (i_framing_error_selector) begin
			rdata_nxt[uscr_pkg::BIT_SEL0_FE] = fe_nxt;
		end
		if (i_reset) begin
			rdata_nxt = uscr_pkg::SCS_RESET;
		end
	end

	// Mode decode from the two mode bits, one-hot. [RL5] [RL6]
	always_comb begin
		case ({ctl_nxt[uscr_pkg::BIT_SEL0_FE], ctl_nxt[uscr_pkg::BIT_SEL1]})
			uscr_pkg::MODE_CODE_SHIFT: mode_nxt = uscr_pkg::USCR_MODE_SHIFT;
			uscr_pkg::MODE_CODE_UART8: mode_nxt = uscr_pkg::USCR_MODE_UART8;
			uscr_pkg::MODE_CODE_UART9_FIXED: begin
				mode_nxt = uscr_pkg::USCR_MODE_UART9_FIXED;
			end
			uscr_pkg::MODE_CODE_UART9_VAR: begin
				mode_nxt = uscr_pkg::USCR_MODE_UART9_VAR;
			end
			default: mode_nxt = uscr_pkg::USCR_MODE_SHIFT;
		endcase
	end

	// State registers; reset is already folded into the next values.
	always_ff @(posedge i_mclk) begin
		ctl_r <= ctl_nxt;
		fe_r <= fe_nxt;
		rdata_r <= rdata_nxt;
		mode_r <= mode_nxt;
	end

	// Every output comes straight from a register.
	assign o_sfr_rdata = rdata_r;
	assign o_mode = mode_r;
	assign o_multiprocessor_enable = ctl_r[uscr_pkg::BIT_MP_EN];
	assign o_receive_enable = ctl_r[uscr_pkg::BIT_RX_EN];
	assign o_transmit_ninth_bit = ctl_r[uscr_pkg::BIT_TX_NINTH];
	assign o_received_ninth_bit = ctl_r[uscr_pkg::BIT_RX_NINTH];
	assign o_transmit_interrupt_flag = ctl_r[uscr_pkg::BIT_TX_FLAG];
	assign o_receive_interrupt_flag = ctl_r[uscr_pkg::BIT_RX_FLAG];
	assign o_framing_error_flag = fe_r;

	// Frame in a nine bit mode that carries no address mark.
	sequence nine_unaddr_s;
		i_rx_done && ctl_r[uscr_pkg::BIT_MP_EN] &&
			ctl_r[uscr_pkg::BIT_SEL0_FE] && !i_rx_ninth_bit;
	endsequence

	// Eight bit frame that arrived without its stop bit.
	sequence eight_no_stop_s;
		i_rx_done && ctl_r[uscr_pkg::BIT_MP_EN] &&
			!ctl_r[uscr_pkg::BIT_SEL0_FE] &&
			ctl_r[uscr_pkg::BIT_SEL1] && !i_rx_stop_bit;
	endsequence

	// Receive flag clear and no software access in the same cycle.
	sequence flag_quiet_s;
		!ctl_r[uscr_pkg::BIT_RX_FLAG] && !sw_touch;
	endsequence

	// Unaddressed nine bit frames must not raise the receive flag.
	mp_ninth_a: assert property ( // [RL7]
		@(posedge i_mclk) disable iff (i_reset)
		nine_unaddr_s ##0 flag_quiet_s |=> !o_receive_interrupt_flag
	) else $error("receive flag raised by unaddressed frame");

	// Eight bit frames without stop bit must not raise the receive flag.
	mp_stop_a: assert property ( // [RL7]
		@(posedge i_mclk) disable iff (i_reset)
		eight_no_stop_s ##0 flag_quiet_s |=> !o_receive_interrupt_flag
	) else $error("receive flag raised without stop bit");

	// A missing stop bit always leaves the error flag set.
	fe_set_a: assert property ( // [RL3]
		@(posedge i_mclk) disable iff (i_reset)
		i_rx_done && !i_rx_stop_bit |=> o_framing_error_flag
	) else $error("framing error flag not set");

	// The error flag stays set while software leaves the register alone.
	fe_sticky_a: assert property ( // [RL4]
		@(posedge i_mclk) disable iff (i_reset)
		fe_r && !sw_touch |=> fe_r
	) else $error("framing error flag dropped by itself");

	// Read position 7 follows the selector.
	bit7_view_a: assert property ( // [RL2]
		@(posedge i_mclk) disable iff (i_reset)
		o_sfr_rdata[7] == ($past(i_framing_error_selector) ? fe_r : ctl_r[7])
	) else $error("bit 7 view does not follow selector");

	// The mode output matches the two stored mode bits.
	mode_decode_a: assert property ( // [RL5] [RL6]
		@(posedge i_mclk) disable iff (i_reset)
		o_mode == (4'h1 << {ctl_r[7], ctl_r[6]})
	) else $error("mode output does not match mode bits");

	// Writes to bit 7 with the selector set leave mode bit 0 alone.
	sm0_guard_a: assert property ( // [RL8]
		@(posedge i_mclk) disable iff (i_reset)
		(byte_hit || bit_hit[7]) && i_framing_error_selector |=>
			$stable(ctl_r[7])
	) else $error("mode bit 0 changed while hidden");

	// Transmit done always leaves the transmit flag set.
	tx_flag_a: assert property ( // [RL1]
		@(posedge i_mclk) disable iff (i_reset)
		i_tx_done |=> o_transmit_interrupt_flag
	) else $error("transmit flag not set");
endmodule // uscr_ctrl

// ### rtl/uscr_pkg.sv
package uscr_pkg;
	// Special function register address and reset value of the register.
	localparam logic [7:0] SCS_ADDR = 8'h98;
	localparam logic [7:0] SCS_RESET = 8'h00;
	// Bit positions inside the control and status register.
	localparam int BIT_SEL0_FE = 7;
	localparam int BIT_SEL1 = 6;
	localparam int BIT_MP_EN = 5;
	localparam int BIT_RX_EN = 4;
	localparam int BIT_TX_NINTH = 3;
	localparam int BIT_RX_NINTH = 2;
	localparam int BIT_TX_FLAG = 1;
	localparam int BIT_RX_FLAG = 0;
	// Bit address span covered by the register, one bit per address.
	localparam logic [4:0] SCS_BIT_BASE = 5'h13;
	// Mode code values formed as {mode_select_bit0, mode_select_bit1}.
	localparam logic [1:0] MODE_CODE_SHIFT = 2'h0;
	localparam logic [1:0] MODE_CODE_UART8 = 2'h1;
	localparam logic [1:0] MODE_CODE_UART9_FIXED = 2'h2;
	localparam logic [1:0] MODE_CODE_UART9_VAR = 2'h3;
	// Decoded operating mode, one-hot.
	typedef enum logic [3:0] {
		USCR_MODE_SHIFT = 4'h1,
		USCR_MODE_UART8 = 4'h2,
		USCR_MODE_UART9_FIXED = 4'h4,
		USCR_MODE_UART9_VAR = 4'h8
	} uscr_mode_e;
endpackage

// ### verif/uscr_ctrl_test.sv
`define CK(n,e,s) begin samples_checked++; if ((s)!==(e)) begin num_errors++;\
 $display("MISMATCH %s exp %h got %h",n,e,s); end end
module uscr_ctrl_test;
timeunit 1ns;
timeprecision 1ps;
logic i_mclk=0,i_reset=1,i_sfr_wr=0,i_bit_wr=0,i_bit_val=0;
logic i_framing_error_selector=0,i_tx_done=0,i_rx_done=0;
logic i_rx_stop_bit=1,i_rx_ninth_bit=0,o_multiprocessor_enable;
logic [7:0] i_sfr_addr=8'h98,i_sfr_wdata=8'h00,i_bit_addr=8'h00,o_sfr_rdata;
logic [3:0] o_mode;
logic o_receive_enable,o_transmit_ninth_bit,o_received_ninth_bit;
logic o_transmit_interrupt_flag,o_receive_interrupt_flag,o_framing_error_flag;
int num_errors=0,samples_checked=0;
uscr_ctrl uscr_ctrl_i (.*);
initial forever #5 i_mclk=~i_mclk;
task stop_test;
	$display("errors %0d checks %0d",num_errors,samples_checked);
	if (num_errors==0 && samples_checked>0) $display("TB: PASS");
	else $display("TB: FAIL");
	$finish;
endtask
// Each access strobes for one cycle, launched just after the edge.
task wr(input logic [7:0] d); @(posedge i_mclk) #1 i_sfr_wdata<=d;
	i_sfr_wr<=1; @(posedge i_mclk) #1 i_sfr_wr<=0; endtask
task rx(input logic s); @(posedge i_mclk) #1 i_rx_stop_bit<=s;
	i_rx_done<=1; @(posedge i_mclk) #1 i_rx_done<=0; endtask
task bw(input logic [7:0] a, input logic v); @(posedge i_mclk) #1;
	i_bit_addr<=a; i_bit_val<=v; i_bit_wr<=1;
	@(posedge i_mclk) #1 i_bit_wr<=0; endtask
initial begin
	repeat (4) @(posedge i_mclk); #1 i_reset<=0; #1;
	`CK("reset",8'h00,o_sfr_rdata)
	wr(8'h5a); @(posedge i_mclk) #1;
	`CK("rdata",8'h5a,o_sfr_rdata)
	`CK("mode",4'h2,o_mode)
	`CK("ti",1'b1,o_transmit_interrupt_flag)
	`CK("tb8",1'b1,o_transmit_ninth_bit)
	i_framing_error_selector<=1; rx(1'b0); rx(1'b1); @(posedge i_mclk) #1;
	`CK("fe",1'b1,o_framing_error_flag)
	`CK("bit7",1'b1,o_sfr_rdata[7])
	`CK("ri",1'b1,o_receive_interrupt_flag)
	`CK("rb8",1'b1,o_received_ninth_bit)
	i_framing_error_selector<=0; wr(8'hf0); @(posedge i_mclk) #1;
	`CK("mode3",4'h8,o_mode)
	`CK("mpen",1'b1,o_multiprocessor_enable)
	`CK("ren",1'b1,o_receive_enable)
	rx(1'b1); @(posedge i_mclk) #1;
	`CK("ri_mp",1'b0,o_receive_interrupt_flag)
	`CK("fe_kept",1'b1,o_framing_error_flag)
	i_framing_error_selector<=1; bw(8'h9f,1'b0); @(posedge i_mclk) #1;
	`CK("fe_clr",1'b0,o_framing_error_flag)
	`CK("sm0_kept",4'h8,o_mode)
	`CK("view",8'h70,o_sfr_rdata)
	stop_test;
end
initial begin #5000; num_errors++; stop_test; end
endmodule // uscr_ctrl_test
